// *** dsp_top.sv ***
// Host glue for a two-port serial adapter: decode, routing, drivers.
// Assumes a host master on clk with one-cycle read and write strobes.
`timescale 1ns/1ps
module dsp_top (
  input  wire logic                         clk,
  input  wire logic                         resetn,
  input  wire logic [dsp_pkg::ADDR_W-1:0]   host_addr,
  input  wire logic [dsp_pkg::DATA_W-1:0]   host_wdata,
  input  wire logic                         host_wr,
  input  wire logic                         host_rd,
  output logic      [dsp_pkg::DATA_W-1:0]   host_rdata,
  input  wire logic [dsp_pkg::SW_W-1:0]     port_one_address_switch,
  input  wire logic [dsp_pkg::SW_W-1:0]     port_two_address_switch,
  input  wire logic [dsp_pkg::NLINE-1:0]    irq_route_header_a,
  input  wire logic [dsp_pkg::NLINE-1:0]    irq_route_header_b,
  input  wire logic                         port_one_driver_gate_jumper,
  input  wire logic                         port_two_driver_gate_jumper,
  output logic      [dsp_pkg::NPORT-1:0]    uart_cs,
  output logic                              uart_wr,
  output logic                              uart_rd,
  output logic      [dsp_pkg::REG_SEL_W-1:0] uart_reg_sel,
  output logic      [dsp_pkg::DATA_W-1:0]   uart_wdata,
  input  wire logic [dsp_pkg::DATA_W-1:0]   uart1_rdata,
  input  wire logic [dsp_pkg::DATA_W-1:0]   uart2_rdata,
  input  wire logic [dsp_pkg::NPORT-1:0]    uart_irq,
  input  wire logic [dsp_pkg::NPORT-1:0]    uart_rts,
  output logic      [dsp_pkg::NLINE-1:0]    irq_line_o,
  output logic      [dsp_pkg::NLINE-1:0]    irq_line_oe,
  output logic      [dsp_pkg::NPORT-1:0]    drv_en,
  output logic                              irq_out
);
  import dsp_pkg::*;

  dsp_port_if pif [NPORT] ();

  logic [SW_W-1:0]      sw_pin    [NPORT];
  logic [NLINE-1:0]     route_pin [NPORT];
  logic [NPORT-1:0]     gate_pin;
  logic [NLINE-1:0]     line_o_p  [NPORT];
  logic [NLINE-1:0]     line_oe_p [NPORT];
  logic [NPORT-1:0]     hit;
  logic [NPORT-1:0]     irq_s;
  logic [NPORT-1:0]     irq_event;
  logic                 strobe;
  logic                 ctrl_hit;
  logic                 clr_status;
  logic                 wr_mask;
  logic [REG_SEL_W-1:0] ofs;

  logic [NPORT-1:0]  status_reg, status_next;
  logic [NPORT-1:0]  mask_reg, mask_next;
  logic [NPORT-1:0]  irq_prev_reg, irq_prev_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  // Switch pattern as the address bits it selects, A9 first
  function automatic logic [BASE_SW_W-1:0] base_of(
      input logic [SW_W-1:0] sw);
    logic [BASE_SW_W-1:0] b;
    b = '0;
    for (int i = 0; i < BASE_SW_W; i++) begin
      b[BASE_SW_W-1-i] = sw[i];
    end
    return b;
  endfunction

  function automatic logic [DATA_W-1:0] widen_port(
      input logic [NPORT-1:0] v);
    return {{(DATA_W-NPORT){1'b0}}, v};
  endfunction

  assign sw_pin[0]    = port_one_address_switch;
  assign sw_pin[1]    = port_two_address_switch;
  assign route_pin[0] = irq_route_header_a;
  assign route_pin[1] = irq_route_header_b;
  assign gate_pin[0]  = port_one_driver_gate_jumper;
  assign gate_pin[1]  = port_two_driver_gate_jumper;

  // Each slice keeps its own decode, enable, route and gate
  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_port
      assign pif[p].addr = host_addr;
      assign hit[p]      = pif[p].hit;
      assign irq_s[p]    = pif[p].irq_s;
      dsp_port u_port (
        .clk         (clk),
        .resetn      (resetn),
        .bus         (pif[p]),
        .addr_switch (sw_pin[p]),
        .irq_route   (route_pin[p]),
        .gate_jumper (gate_pin[p]),
        .uart_irq    (uart_irq[p]),
        .uart_rts    (uart_rts[p]),
        .irq_line_o  (line_o_p[p]),
        .irq_line_oe (line_oe_p[p]),
        .drv_en      (drv_en[p])
      );
    end
  endgenerate

  // Wired line: enables combine, low level is shared
  assign irq_line_oe = line_oe_p[0] | line_oe_p[1];
  assign irq_line_o  = line_o_p[0] & line_o_p[1];

  assign strobe = host_wr || host_rd;
  assign ofs    = host_addr[REG_SEL_W-1:0];

  // Port one wins if both banks are set to the same block
  assign uart_cs[0] = strobe && hit[0];
  assign uart_cs[1] = strobe && hit[1] && !hit[0];
  // Controller owns buffers, rate and format behind these strobes
  assign uart_wr      = host_wr;
  assign uart_rd      = host_rd;
  assign uart_reg_sel = ofs;
  assign uart_wdata   = host_wdata;

  // Local block yields to any serial port placed over it
  assign ctrl_hit = (host_addr[ADDR_W-1:REG_SEL_W]
                     == CTRL_BASE[ADDR_W-1:REG_SEL_W]) && (hit == '0);
  assign clr_status = host_wr && ctrl_hit && (ofs == OFS_STATUS);
  assign wr_mask    = host_wr && ctrl_hit && (ofs == OFS_MASK);

  assign irq_event = irq_s & ~irq_prev_reg;

  always_comb begin
    irq_prev_next = irq_s;
    // New event beats a same-cycle write-one clear
    status_next   = status_reg;
    if (clr_status) begin
      status_next = status_reg & ~host_wdata[NPORT-1:0];
    end
    status_next = status_next | irq_event;
    mask_next   = wr_mask ? host_wdata[NPORT-1:0] : mask_reg;
    rdata_next  = '0;
    if (host_rd) begin
      if (hit[0]) begin
        rdata_next = uart1_rdata;
      end else if (hit[1]) begin
        rdata_next = uart2_rdata;
      end else if (ctrl_hit && ofs == OFS_STATUS) begin
        rdata_next = widen_port(status_reg);
      end else if (ctrl_hit && ofs == OFS_MASK) begin
        rdata_next = widen_port(mask_reg);
      end else if (ctrl_hit && ofs == OFS_SW1) begin
        rdata_next = pif[0].sw_s;
      end else if (ctrl_hit && ofs == OFS_SW2) begin
        rdata_next = pif[1].sw_s;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_reg   <= '0;
      mask_reg     <= '0;
      irq_prev_reg <= '0;
      rdata_reg    <= '0;
    end else begin
      status_reg   <= status_next;
      mask_reg     <= mask_next;
      irq_prev_reg <= irq_prev_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign host_rdata = rdata_reg;
  assign irq_out    = |(status_reg & mask_reg);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Decode, enable and pass-through of host accesses, line sharing and status capture
  AST_BLOCK_HIT: assert property (
    (strobe && !pif[0].sw_s[SW_EN_POS]
     && host_addr[ADDR_W-1:REG_SEL_W] == base_of(pif[0].sw_s))
    |-> uart_cs[0])
    else $error("port one missed an access in its block");
  AST_BASE_BITS: assert property (
    uart_cs[1] |->
    host_addr[ADDR_W-1:REG_SEL_W] == base_of(pif[1].sw_s))
    else $error("port two selected outside its block");
  AST_CLOSED_ZERO: assert property (
    (uart_cs[0] && !pif[0].sw_s[0]) |-> !host_addr[ADDR_W-1])
    else $error("closed position accepted a one");
  AST_DISABLED_CS: assert property (
    pif[1].sw_s[SW_EN_POS] |-> !uart_cs[1])
    else $error("disabled port two selected");
  AST_RD_PASS: assert property (
    (host_rd && uart_cs[0]) |=> host_rdata == $past(uart1_rdata))
    else $error("port one read data not returned");
  AST_RD_ONLY: assert property (
    !$past(host_rd) |-> host_rdata == '0)
    else $error("read data outside the answer cycle");
  AST_INDEP: assert property (
    (host_wr && hit[1] && !hit[0]) |-> (uart_cs == 2'h2))
    else $error("port two access disturbed port one");
  AST_SHARE: assert property (
    (line_oe_p[0][LINE_IRQ4] || line_oe_p[1][LINE_IRQ4])
    |-> irq_line_oe[LINE_IRQ4] && !irq_line_o[LINE_IRQ4])
    else $error("shared request line not pulled low");
  AST_BASE_300: assert property (
    (pif[1].sw_s == 8'h03 && !hit[0] && host_rd && host_addr == 10'h300)
    |-> uart_cs[1])
    else $error("base 300 not decoded");
  AST_BASE_3F8: assert property (
    (pif[0].sw_s == FACTORY_SW_P1 && strobe && host_addr == 10'h3ff)
    |-> uart_cs[0] && uart_reg_sel == 3'h7)
    else $error("base 3F8 not decoded");
  AST_STICKY: assert property (
    irq_event[0] |=> status_reg[0]
    ##1 (status_reg[0] || $past(clr_status && host_wdata[0])))
    else $error("interrupt event lost");
  AST_CLEAR: assert property (
    (clr_status && host_wdata[0] && !irq_event[0]) |=> !status_reg[0])
    else $error("status bit not cleared by write one");
  AST_IRQ_OUT: assert property (
    (irq_event[1] && mask_reg[1] && !wr_mask) |=> irq_out)
    else $error("unmasked event gave no interrupt");

  // Local block, chip selects and read path; a stale word must never leak out
  AST_SET_WINS: assert property (
    (irq_event[0] && clr_status && host_wdata[0]) |=> status_reg[0])
    else $error("same-cycle clear beat an interrupt event");
  AST_STATUS_HOLD: assert property (
    (irq_event == '0 && !clr_status) |=> status_reg == $past(status_reg))
    else $error("status changed with no event or clear");
  AST_EVENT_P2: assert property (
    irq_event[1] |=> status_reg[1])
    else $error("port two interrupt event lost");
  AST_CLEAR_P2: assert property (
    (clr_status && host_wdata[1] && !irq_event[1]) |=> !status_reg[1])
    else $error("port two status not cleared by write one");
  AST_IRQ_OUT_P1: assert property (
    (irq_event[0] && mask_reg[0] && !wr_mask) |=> irq_out)
    else $error("unmasked port one event gave no interrupt");
  AST_MASK_WR: assert property (
    wr_mask |=> mask_reg == $past(host_wdata[NPORT-1:0]))
    else $error("mask write not taken");
  AST_MASK_HOLD: assert property (
    !wr_mask |=> mask_reg == $past(mask_reg))
    else $error("mask changed without a write");
  AST_YIELD: assert property (
    (host_wr && hit != '0) |=> mask_reg == $past(mask_reg))
    else $error("port write reached the local block");
  AST_CS_IDLE: assert property (
    !strobe |-> uart_cs == '0)
    else $error("chip select without a strobe");
  AST_CS_ONE: assert property (
    $onehot0(uart_cs))
    else $error("both controllers selected at once");
  AST_RD_PASS2: assert property (
    (host_rd && uart_cs[1]) |=> host_rdata == $past(uart2_rdata))
    else $error("port two read data not returned");
  AST_RD_STATUS: assert property (
    (host_rd && ctrl_hit && ofs == OFS_STATUS)
    |=> host_rdata[NPORT-1:0] == $past(status_reg)
    && host_rdata[DATA_W-1:NPORT] == '0)
    else $error("status read wrong");
  AST_RD_MASK: assert property (
    (host_rd && ctrl_hit && ofs == OFS_MASK)
    |=> host_rdata[NPORT-1:0] == $past(mask_reg))
    else $error("mask read wrong");
  AST_RD_SW1: assert property (
    (host_rd && ctrl_hit && ofs == OFS_SW1)
    |=> host_rdata == $past(pif[0].sw_s))
    else $error("port one switch read wrong");
  AST_RD_SW2: assert property (
    (host_rd && ctrl_hit && ofs == OFS_SW2)
    |=> host_rdata == $past(pif[1].sw_s))
    else $error("port two switch read wrong");
  AST_RD_HIGH: assert property (
    (host_rd && ctrl_hit && ofs[REG_SEL_W-1]) |=> host_rdata == '0)
    else $error("unused local offset read nonzero");
  AST_RD_UNMAPPED: assert property (
    (host_rd && hit == '0 && !ctrl_hit) |=> host_rdata == '0)
    else $error("unmapped read returned data");

  // Main scenarios, for coverage only
  COV_FACTORY_P1: cover property (
    pif[0].sw_s == FACTORY_SW_P1 && uart_cs[0]
    && line_oe_p[0] == FACTORY_ROUTE_P1);
  COV_FACTORY_P2: cover property (
    pif[1].sw_s == FACTORY_SW_P2 && uart_cs[1]
    && line_oe_p[1] == FACTORY_ROUTE_P2);
  COV_SHARED: cover property (
    line_oe_p[0][LINE_IRQ3] && line_oe_p[1][LINE_IRQ3]);
  COV_IRQ_OUT: cover property (irq_event[0] ##1 irq_out);
  COV_SET_WINS: cover property (irq_event[0] && clr_status && host_wdata[0]);
endmodule

// *** dsp_pkg.sv ***
// Shared constants for the dual serial port address decode block.
// Assumes a 10-bit host I/O address and 8-bit host data.
package dsp_pkg;
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 8;
  localparam int NPORT     = 2;
  localparam int NLINE     = 4;
  localparam int SW_W      = 8;
  localparam int BASE_SW_W = 7;
  localparam int REG_SEL_W = 3;
  localparam int SW_EN_POS = 7;

  // Request line order on the route headers and line pins
  localparam int LINE_IRQ2_9 = 0;
  localparam int LINE_IRQ3   = 1;
  localparam int LINE_IRQ4   = 2;
  localparam int LINE_IRQ5   = 3;

  // Switch bit i is position i+1; a one means open
  localparam logic [SW_W-1:0]  FACTORY_SW_P1    = 8'h7f;
  localparam logic [SW_W-1:0]  FACTORY_SW_P2    = 8'h7d;
  localparam logic [NLINE-1:0] FACTORY_ROUTE_P1 = 4'h4;
  localparam logic [NLINE-1:0] FACTORY_ROUTE_P2 = 4'h2;

  // Local interrupt block, eight locations
  localparam logic [ADDR_W-1:0]    CTRL_BASE  = 10'h100;
  localparam logic [REG_SEL_W-1:0] OFS_STATUS = 3'h0;
  localparam logic [REG_SEL_W-1:0] OFS_MASK   = 3'h1;
  localparam logic [REG_SEL_W-1:0] OFS_SW1    = 3'h2;
  localparam logic [REG_SEL_W-1:0] OFS_SW2    = 3'h3;

  // Synchroniser word {switch, route, gate, irq, rts}
  localparam int SYNC_W      = 15;
  localparam int F_SW_LSB    = 7;
  localparam int F_ROUTE_LSB = 3;
  localparam int F_GATE      = 2;
  localparam int F_IRQ       = 1;
  localparam int F_RTS       = 0;
  // Port disabled and nothing routed until the pins are seen
  localparam logic [SYNC_W-1:0] SYNC_RST = 15'h7f80;
endpackage

// *** dsp_port_if.sv ***
// Interface between the top and one port decode slice.
// Assumes the host address is already on the block clock.
`timescale 1ns/1ps
interface dsp_port_if;
  import dsp_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              hit;
  logic              irq_s;
  logic [SW_W-1:0]   sw_s;
  modport host (output addr, input hit, irq_s, sw_s);
  modport port (input addr, output hit, irq_s, sw_s);
endinterface

// *** dsp_port.sv ***
// One serial port slice: pin filtering, base decode, request drive.
// Assumes switch, jumper, irq and rts pins are asynchronous to clk.
`timescale 1ns/1ps
module dsp_port (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  dsp_port_if.port                      bus,
  input  wire logic [dsp_pkg::SW_W-1:0] addr_switch,
  input  wire logic [dsp_pkg::NLINE-1:0] irq_route,
  input  wire logic                     gate_jumper,
  input  wire logic                     uart_irq,
  input  wire logic                     uart_rts,
  output logic [dsp_pkg::NLINE-1:0]     irq_line_o,
  output logic [dsp_pkg::NLINE-1:0]     irq_line_oe,
  output logic                          drv_en
);
  import dsp_pkg::*;

  logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  logic [SW_W-1:0]   sw_f;
  logic [NLINE-1:0]  route_f;

  function automatic logic base_match(input logic [ADDR_W-1:0] a,
                                      input logic [SW_W-1:0]   sw);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < BASE_SW_W; i++) begin
      if (a[ADDR_W-1-i] != sw[i]) ok = 1'b0;
    end
    return ok;
  endfunction

  // Take a change only once stages two and three agree
  always_comb begin
    filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_reg   <= SYNC_RST;
      s2_reg   <= SYNC_RST;
      s3_reg   <= SYNC_RST;
      filt_reg <= SYNC_RST;
    end else begin
      s1_reg   <= {addr_switch, irq_route, gate_jumper, uart_irq, uart_rts};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  assign sw_f      = filt_reg[F_SW_LSB +: SW_W];
  assign route_f   = filt_reg[F_ROUTE_LSB +: NLINE];
  assign bus.sw_s  = sw_f;
  assign bus.irq_s = filt_reg[F_IRQ];
  // Seven-bit compare of A9..A3, low three bits left free
  assign bus.hit   = base_match(bus.addr, sw_f) && !sw_f[SW_EN_POS];

  // Open drain, active low: any number of ports may share a line
  generate
    for (genvar l = 0; l < NLINE; l++) begin : g_line
      assign irq_line_o[l]  = 1'b0;
      assign irq_line_oe[l] = route_f[l] && filt_reg[F_IRQ];
    end
  endgenerate

  // Software keeps rts on one node only on a shared line
  assign drv_en = filt_reg[F_GATE] ? filt_reg[F_RTS] : 1'b1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_DRV_GATED: assert property (
    (gate_jumper && !uart_rts)[*4] |=> !drv_en)
    else $error("driver on with gate fitted and rts low");
  AST_DRV_FREE: assert property (
    (!gate_jumper)[*4] |=> drv_en[*2])
    else $error("driver off without gate jumper");
  AST_NO_ROUTE: assert property (
    (irq_route == '0)[*4] |=> irq_line_oe == '0)
    else $error("request line driven with no route fitted");
  AST_ROUTE: assert property (
    (uart_irq && $stable(irq_route))[*4] |=> irq_line_oe == $past(irq_route))
    else $error("request not on the selected line");
  AST_DISABLED: assert property (
    (addr_switch[SW_EN_POS])[*4] |=> !bus.hit)
    else $error("disabled port decoded");
endmodule

// *** dsp_host_model.sv ***
// Host processor model: one-cycle I/O strobes on the expansion bus.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
module dsp_host_model (
  input  wire logic                       clk,
  output logic      [dsp_pkg::ADDR_W-1:0] host_addr,
  output logic      [dsp_pkg::DATA_W-1:0] host_wdata,
  output logic                            host_wr,
  output logic                            host_rd,
  input  wire logic [dsp_pkg::DATA_W-1:0] host_rdata,
  input  wire logic [dsp_pkg::NPORT-1:0]  uart_cs
);
  import dsp_pkg::*;
  initial begin
    host_addr  = '0;
    host_wdata = '0;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
  end

  task automatic access(input logic is_wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, output logic [NPORT-1:0] cs,
      output logic [DATA_W-1:0] q);
    @(posedge clk);
    host_addr  <= a;
    host_wdata <= d;
    host_wr    <= is_wr;
    host_rd    <= !is_wr;
    @(negedge clk);
    cs = uart_cs;
    @(posedge clk);
    // Released lines invert so a held stale value cannot pass
    host_addr  <= ~a;
    host_wdata <= ~d;
    host_wr    <= 1'b0;
    host_rd    <= 1'b0;
    @(negedge clk);
    q = host_rdata;
  endtask
endmodule

// *** dual_serial_port_address_decode_tb_top.sv ***
// Self-checking bench for the two-port decode and request routing.
// Assumes the host model above and combinational controller stubs.
`timescale 1ns/1ps
module dual_serial_port_address_decode_tb_top;
  import dsp_pkg::*;
  logic clk;
  logic resetn;
  logic [SW_W-1:0]    sw1;
  logic [SW_W-1:0]    sw2;
  logic [NLINE-1:0]   route_a;
  logic [NLINE-1:0]   route_b;
  logic               gate1;
  logic               gate2;
  logic [NPORT-1:0]   irq;
  logic [NPORT-1:0]   rts;
  logic [ADDR_W-1:0]  haddr;
  logic [DATA_W-1:0]  hwdata;
  logic [DATA_W-1:0]  hrdata;
  logic               hwr;
  logic               hrd;
  logic [NPORT-1:0]   cs;
  logic [REG_SEL_W-1:0] sel;
  logic [NLINE-1:0]   line_o;
  logic [NLINE-1:0]   line_oe;
  logic [NPORT-1:0]   drv;
  logic               irq_out;
  logic [DATA_W-1:0]  u1_rdata;
  logic [DATA_W-1:0]  u2_rdata;
  logic               uwr;
  logic               urd;
  logic [DATA_W-1:0]  uwd;
  int err_count;
  int total_checks;

  // Controller stubs echo the register select so decode shows in data
  assign u1_rdata = {5'h15, sel};
  assign u2_rdata = {5'h0a, sel};

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  dsp_host_model host (.clk(clk), .host_addr(haddr), .host_wdata(hwdata),
    .host_wr(hwr), .host_rd(hrd), .host_rdata(hrdata), .uart_cs(cs));

  dsp_top DUT (.clk(clk), .resetn(resetn), .host_addr(haddr),
    .host_wdata(hwdata), .host_wr(hwr), .host_rd(hrd), .host_rdata(hrdata),
    .port_one_address_switch(sw1), .port_two_address_switch(sw2),
    .irq_route_header_a(route_a), .irq_route_header_b(route_b),
    .port_one_driver_gate_jumper(gate1),
    .port_two_driver_gate_jumper(gate2), .uart_cs(cs), .uart_wr(uwr),
    .uart_rd(urd), .uart_reg_sel(sel), .uart_wdata(uwd),
    .uart1_rdata(u1_rdata),
    .uart2_rdata(u2_rdata), .uart_irq(irq), .uart_rts(rts),
    .irq_line_o(line_o), .irq_line_oe(line_oe), .drv_en(drv),
    .irq_out(irq_out));

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Controllers see the host strobes and write data unchanged
  always @(negedge clk) begin
    if (resetn && (hwr || hrd)) begin
      chk("uart_wr", 8'(hwr), 8'(uwr));
      chk("uart_rd", 8'(hrd), 8'(urd));
      chk("uart_wdata", hwdata, uwd);
    end
  end

  task automatic acc(logic w, logic [ADDR_W-1:0] a, logic [7:0] d,
      logic [NPORT-1:0] exp_cs, logic [7:0] exp_q);
    logic [NPORT-1:0] c;
    logic [7:0] q;
    host.access(w, a, d, c, q);
    chk("uart_cs", 8'(exp_cs), 8'(c));
    if (!w) chk("host_rdata", exp_q, q);
  endtask

  // Port read: data comes from whichever controller was selected
  task automatic dec(logic [ADDR_W-1:0] a, logic [NPORT-1:0] exp_cs);
    logic [7:0] q;
    q = (exp_cs == 2'b01) ? {5'h15, a[2:0]} :
        (exp_cs == 2'b10) ? {5'h0a, a[2:0]} : 8'h00;
    acc(1'b0, a, 8'h00, exp_cs, q);
  endtask

  // Pins pass a filter, so give them time to be seen
  task automatic settle();
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("MISMATCH run_length expected end seen timeout");
    finish_test();
  end

  initial begin
    err_count = 0;
    total_checks = 0;
    resetn = 1'b0;
    sw1 = FACTORY_SW_P1;
    sw2 = FACTORY_SW_P2;
    route_a = FACTORY_ROUTE_P1;
    route_b = FACTORY_ROUTE_P2;
    gate1 = 1'b0;
    gate2 = 1'b0;
    irq = 2'b00;
    rts = 2'b00;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    settle();
    dec(10'h3f8, 2'b01);
    dec(10'h3ff, 2'b01);
    dec(10'h3f7, 2'b00);
    dec(10'h2f8, 2'b10);
    dec(10'h2ff, 2'b10);
    dec(10'h3fa, 2'b01);
    acc(1'b1, 10'h2f9, 8'ha5, 2'b10, 8'h00);
    $display("test factory done");
    @(posedge clk);
    sw1 <= 8'h00;
    sw2 <= 8'h03;
    settle();
    dec(10'h000, 2'b01);
    dec(10'h007, 2'b01);
    dec(10'h008, 2'b00);
    dec(10'h300, 2'b10);
    dec(10'h3f8, 2'b00);
    $display("test switches done");
    @(posedge clk);
    sw1 <= 8'hff;
    sw2 <= FACTORY_SW_P2;
    settle();
    dec(10'h3f8, 2'b00);
    dec(10'h2f8, 2'b10);
    @(posedge clk);
    sw1 <= FACTORY_SW_P1;
    sw2 <= 8'hfd;
    settle();
    dec(10'h2f8, 2'b00);
    dec(10'h3f8, 2'b01);
    @(posedge clk);
    sw2 <= FACTORY_SW_P2;
    $display("test enable done");
    for (int l = 0; l < NLINE; l++) begin
      @(posedge clk);
      route_a <= 4'(1 << l);
      route_b <= 4'h0;
      irq <= 2'b01;
      settle();
      chk("irq_line_oe", 8'(1 << l), 8'(line_oe));
      chk("irq_line_o", 8'h00, 8'(line_o));
    end
    @(posedge clk);
    route_a <= 4'h4;
    route_b <= 4'h4;
    irq <= 2'b11;
    settle();
    chk("irq_line_oe", 8'h04, 8'(line_oe));
    @(posedge clk);
    route_a <= 4'h0;
    irq <= 2'b01;
    settle();
    chk("irq_line_oe", 8'h00, 8'(line_oe));
    $display("test routing done");
    @(posedge clk);
    gate1 <= 1'b1;
    settle();
    chk("drv_en", 8'h02, 8'(drv));
    @(posedge clk);
    rts <= 2'b01;
    settle();
    chk("drv_en", 8'h03, 8'(drv));
    @(posedge clk);
    gate2 <= 1'b1;
    rts <= 2'b10;
    settle();
    chk("drv_en", 8'h02, 8'(drv));
    $display("test gating done");
    @(posedge clk);
    irq <= 2'b00;
    settle();
    acc(1'b1, CTRL_BASE, 8'h03, 2'b00, 8'h00);
    acc(1'b0, CTRL_BASE, 8'h00, 2'b00, 8'h00);
    @(posedge clk);
    irq <= 2'b01;
    settle();
    acc(1'b0, CTRL_BASE, 8'h00, 2'b00, 8'h01);
    chk("irq_out", 8'h00, 8'(irq_out));
    acc(1'b1, CTRL_BASE + 10'h001, 8'h01, 2'b00, 8'h00);
    acc(1'b0, CTRL_BASE + 10'h001, 8'h00, 2'b00, 8'h01);
    settle();
    chk("irq_out", 8'h01, 8'(irq_out));
    acc(1'b1, CTRL_BASE, 8'h01, 2'b00, 8'h00);
    acc(1'b0, CTRL_BASE, 8'h00, 2'b00, 8'h00);
    settle();
    chk("irq_out", 8'h00, 8'(irq_out));
    acc(1'b0, CTRL_BASE + 10'h002, 8'h00, 2'b00, FACTORY_SW_P1);
    acc(1'b0, CTRL_BASE + 10'h003, 8'h00, 2'b00, FACTORY_SW_P2);
    acc(1'b0, CTRL_BASE + 10'h004, 8'h00, 2'b00, 8'h00);
    acc(1'b0, CTRL_BASE + 10'h008, 8'h00, 2'b00, 8'h00);
    // Both ports unmasked, then both raise an event together
    acc(1'b1, CTRL_BASE + 10'h001, 8'h03, 2'b00, 8'h00);
    @(posedge clk);
    irq <= 2'b00;
    settle();
    chk("irq_out", 8'h00, 8'(irq_out));
    @(posedge clk);
    irq <= 2'b11;
    settle();
    chk("irq_out", 8'h01, 8'(irq_out));
    acc(1'b0, CTRL_BASE, 8'h00, 2'b00, 8'h03);
    $display("test interrupts done");
    finish_test();
  end
endmodule
